// ===== rtl/sapr_top.sv
// Purpose: Conversion sequencer and tri-state parallel result port
// Assumes: Host pins are synchronous to clock; the analog core hands
//          raw offset-binary codes over a valid/ready stream
// Notes: A conversion waits at its end for a code if the FIFO is empty
//
// What this block does and what it expects of the host
// [RULE1] Result lines undriven while chip select high, convert selected, or converting.
// [RULE2] Chip select falling with convert selected starts a conversion unless one runs.
// [RULE3] Chip select low with read selected and idle drives the stored result.
// [RULE4] Busy goes low at conversion start and high once it fully completes.
// [RULE5] Result valid on the bus before busy rises when reading is selected.
// [RULE6] Host must deselect soon after busy rises, else another conversion starts.
// [RULE7] Sixteen result lines, line 15 most significant, line 0 least.
// [RULE8] Results are two's complement: 7fff top, 0000 mid, 8000 bottom.
// [RULE9] Host lowers read/convert select well before chip select falls.
// [RULE10] Host spaces conversion starts about four microseconds apart.
// [RULE11] The latest result is kept for later reads until replaced.

module sapr_top
    import sapr_pkg::*;
#(
    parameter int WIDTH = RESULT_W,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int CONV_CNT = CONV_CYCLES,
    parameter int VALID_CNT = DATA_VALID_CYCLES,
    parameter int REARM_CNT = REARM_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Host control pins
    input wire logic read_sel,
    input wire logic cs_n,
    output logic busy_n,
    // Result bus, tri-state outputs
    output logic [WIDTH-1:0] result_o,
    output logic [WIDTH-1:0] result_oe,
    // Raw codes from the analog core
    input wire logic sample_valid,
    input wire logic [WIDTH-1:0] sample_data,
    output logic sample_ready,
    // Status
    output logic result_fresh
);

    localparam int CW = 8;
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CNT - VALID_CNT - 1);
    localparam logic [CW-1:0] VALID_LAST = CW'(VALID_CNT - 1);
    localparam logic [CW-1:0] REARM_LAST = CW'(REARM_CNT - 1);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        sapr_state_t fsm;
        logic [CW-1:0] cnt;
        logic rearm_on;
        logic [CW-1:0] rearm_cnt;
        logic cs_n_prev;
        logic busy_n;
        logic fresh;
        logic [WIDTH-1:0] result;
    } sapr_top_st_t;

    sapr_top_st_t st_q;
    sapr_top_st_t st_d;

    sapr_stream_if #(.WIDTH(WIDTH)) in_s ();
    sapr_stream_if #(.WIDTH(WIDTH)) out_s ();

    logic cs_fall;
    logic start_edge;
    logic start_auto;
    logic converting;
    logic drive_bus;
    logic [WIDTH-1:0] coded;

    // ****************************************************************
    // Sample buffer
    // ****************************************************************
    // Back-pressure reaches the analog core through sample_ready
    assign in_s.valid = sample_valid;
    assign in_s.data = sample_data;
    assign sample_ready = in_s.ready;

    sapr_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .wr(in_s),
        .rd(out_s)
    );

    // ****************************************************************
    // Output coding
    // ****************************************************************
    // Offset binary to two's complement: only the top bit flips
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_code
            if (gi == WIDTH - 1)
            begin : g_top
                assign coded[gi] = ~out_s.data[gi]; // RULE8
            end
            else
            begin : g_rest
                assign coded[gi] = out_s.data[gi]; // RULE8
            end
        end
    endgenerate

    // ****************************************************************
    // Start detection
    // ****************************************************************
    assign cs_fall = st_q.cs_n_prev & ~cs_n;
    assign converting = (st_q.fsm == SAPR_CONV);
    // Edges that arrive while busy is low are dropped, not queued
    assign start_edge = cs_fall & ~read_sel & (st_q.fsm == SAPR_IDLE); // RULE2
    // Host left both pins low through the window after busy rose
    assign start_auto = st_q.rearm_on & (st_q.rearm_cnt == REARM_LAST)
        & ~cs_n & ~read_sel & (st_q.fsm == SAPR_IDLE); // RULE6

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        st_d.cs_n_prev = cs_n;
        out_s.ready = 1'b0;
        if (st_q.rearm_on)
        begin
            if (st_q.rearm_cnt == REARM_LAST || cs_n || read_sel)
            begin
                st_d.rearm_on = 1'b0;
            end
            else
            begin
                st_d.rearm_cnt = st_q.rearm_cnt + CW'(1);
            end
        end
        unique case (st_q.fsm)
            SAPR_IDLE:
            begin
                if (start_edge || start_auto)
                begin
                    st_d.fsm = SAPR_CONV; // RULE2
                    st_d.cnt = '0;
                    st_d.rearm_on = 1'b0;
                end
            end
            SAPR_CONV:
            begin
                if (st_q.cnt != CONV_LAST)
                begin
                    st_d.cnt = st_q.cnt + CW'(1);
                end
                else if (out_s.valid)
                begin
                    // Stall here until the core delivers a code
                    out_s.ready = 1'b1;
                    st_d.result = coded; // RULE11
                    st_d.fresh = 1'b1;
                    st_d.fsm = SAPR_VALID;
                    st_d.cnt = '0;
                end
            end
            SAPR_VALID:
            begin
                // Bus may already be driven here, ahead of busy rising
                if (st_q.cnt != VALID_LAST)
                begin
                    st_d.cnt = st_q.cnt + CW'(1);
                end
                else
                begin
                    st_d.fsm = SAPR_IDLE; // RULE5
                    st_d.rearm_on = 1'b1;
                    st_d.rearm_cnt = '0;
                end
            end
        endcase
        st_d.busy_n = (st_d.fsm == SAPR_IDLE); // RULE4
        if (drive_bus)
        begin
            st_d.fresh = 1'b0;
        end
        if (st_q.fsm == SAPR_CONV && st_d.fsm == SAPR_VALID)
        begin
            // A new result outranks a read in the same cycle
            st_d.fresh = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q.fsm <= SAPR_IDLE;
            st_q.cnt <= '0;
            st_q.rearm_on <= 1'b0;
            st_q.rearm_cnt <= '0;
            st_q.cs_n_prev <= 1'b1;
            st_q.busy_n <= 1'b1;
            st_q.fresh <= 1'b0;
            st_q.result <= WIDTH'(RESULT_RESET);
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Result bus
    // ****************************************************************
    assign drive_bus = ~cs_n & read_sel & ~converting; // RULE1 RULE3
    assign result_o = st_q.result; // RULE7
    assign result_oe = {WIDTH{drive_bus}}; // RULE1
    assign busy_n = st_q.busy_n; // RULE4
    assign result_fresh = st_q.fresh;

endmodule

// ===== rtl/sapr_pkg.sv
// Purpose: Shared constants and types of the converter readout block
// Assumes: 25 MHz system clock, result words of 16 bits
// Notes: Cycle counts are derived from the printed times below

package sapr_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;

    // Busy low for a whole conversion, typical figure
    localparam int CONV_TIME_NS = 3300;
    localparam int CONV_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
        CONV_TIME_NS / CLK_PERIOD_NS;

    // Least time the result is on the bus before busy rises, rounded up
    localparam int DATA_VALID_NS = 25;
    localparam int DATA_VALID_CYCLES =
        (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Wait after busy rises before an automatic restart, rounded up so a
    // host that deselects late in the window is never cut short
    localparam int REARM_WINDOW_NS = 250;
    localparam int REARM_CYCLES =
        (REARM_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host guidance, kept for reference only, not used by the RTL or the bench
    localparam int START_LEAD_NS = 100;
    localparam int THROUGHPUT_US = 4;

    // ****************************************************************
    // Data format
    // ****************************************************************
    localparam int RESULT_W = 16;
    localparam int RESULT_TOP_BIT = 15;
    localparam int RESULT_BOTTOM_BIT = 0;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] CODE_POS_FULL = 16'h7fff;
    localparam logic [15:0] CODE_NEG_FULL = 16'h8000;
    localparam int FIFO_DEPTH = 8;

    // ****************************************************************
    // Conversion sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        SAPR_IDLE,
        SAPR_CONV,
        SAPR_VALID
    } sapr_state_t;

endpackage

// ===== rtl/sapr_stream_if.sv
// Purpose: Valid/ready word stream between the block's own modules
// Assumes: One clock for both ends
// Notes: Data only counts in a cycle where valid and ready are both high

interface sapr_stream_if #(
    parameter int WIDTH = 16
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (
        output valid,
        output data,
        input ready
    );

    modport snk (
        input valid,
        input data,
        output ready
    );
endinterface

// ===== rtl/sapr_fifo.sv
// Purpose: Small word FIFO between the sample source and the sequencer
// Assumes: Depth is a power of two
// Notes: Full and empty come straight from the occupancy count

module sapr_fifo
    import sapr_pkg::*;
#(
    parameter int WIDTH = RESULT_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Filling side
    sapr_stream_if.snk wr,
    // Draining side
    sapr_stream_if.src rd
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } sapr_fifo_st_t;

    sapr_fifo_st_t st_q;
    sapr_fifo_st_t st_d;
    logic push;
    logic pop;

    // ****************************************************************
    // Handshakes
    // ****************************************************************
    assign wr.ready = (st_q.count != (AW+1)'(DEPTH));
    assign rd.valid = (st_q.count != '0);
    assign rd.data = st_q.mem[st_q.rptr];
    assign push = wr.valid & wr.ready;
    assign pop = rd.valid & rd.ready;

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.mem[st_q.wptr] = wr.data;
            st_d.wptr = st_q.wptr + AW'(1);
        end
        if (pop)
        begin
            st_d.rptr = st_q.rptr + AW'(1);
        end
        unique case ({push, pop})
            2'b10: st_d.count = st_q.count + (AW+1)'(1);
            2'b01: st_d.count = st_q.count - (AW+1)'(1);
            default: st_d.count = st_q.count;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

endmodule

// ===== dv/sapr_top_monitor.sv
// Purpose: Port checks of the converter readout block
// Assumes: Bound to sapr_top, one clock domain
// Notes: Busy length is a lower bound, an empty FIFO may stretch it
// ************
// Checker
// ************
module sapr_top_monitor #(
    parameter int WIDTH = 16,
    parameter int CONV_CNT = 82
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Host pins
    input wire logic read_sel,
    input wire logic cs_n,
    input wire logic busy_n,
    input wire logic [WIDTH-1:0] result_o,
    input wire logic [WIDTH-1:0] result_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] low_q;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            low_q <= 12'h000;
        else
            low_q <= busy_n ? 12'h000 : low_q + 12'h001;
    end
    // Host left both pins low through the restart window
    sequence held_low;
        $rose(busy_n) ##0 (!cs_n && !read_sel)[*7];
    endsequence
    sequence mid_conv;
        !busy_n ##1 !busy_n;
    endsequence
    AST_HIZ_CS: assert property (cs_n |-> result_oe == '0)
        else $error("bus driven while deselected");
    AST_HIZ_RC: assert property (!read_sel |-> result_oe == '0)
        else $error("bus driven in convert mode");
    AST_HIZ_BUSY: assert property (mid_conv |-> $past(result_oe) == '0)
        else $error("bus driven mid conversion");
    AST_READ_OE: assert property (!cs_n && read_sel && busy_n |-> result_oe == '1)
        else $error("bus not driven on read");
    AST_START: assert property ($fell(cs_n) && !read_sel && busy_n |=> !busy_n)
        else $error("conversion did not start");
    AST_BUSY_LEN: assert property ($rose(busy_n) |-> low_q >= CONV_CNT)
        else $error("busy released early");
    AST_DATA_LEAD: assert property ($changed(result_o) |=> $rose(busy_n))
        else $error("busy did not follow result");
    AST_VALID_RISE: assert property ($rose(busy_n) && !cs_n && read_sel |->
        $stable(result_o) && $past(result_oe) == '1)
        else $error("result not valid at busy rise");
    AST_REARM: assert property (held_low |-> ##[1:3] !busy_n)
        else $error("no restart after window");
endmodule
bind sapr_top sapr_top_monitor #(.WIDTH(WIDTH), .CONV_CNT(CONV_CNT)) u_mon (
    .clock(clock), .rstn(rstn), .read_sel(read_sel), .cs_n(cs_n), .busy_n(busy_n),
    .result_o(result_o), .result_oe(result_oe));

// ===== dv/sapr_host_model.sv
// Purpose: Host controller driving the select pins
// Assumes: Pins change on the falling clock edge
// Notes: Starts are spaced for acquisition, so runs are slower
// ************
// Host
// ************
module sapr_host_model (
    // Clock
    input wire logic clock,
    // Result bus
    input wire logic [15:0] result_o,
    input wire logic [15:0] result_oe,
    // Control pins
    output logic read_sel = 1'b1,
    output logic cs_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] bus;
    for (genvar i = 0; i < 16; i++)
    begin : g_bus
        assign bus[i] = result_oe[i] ? result_o[i] : 1'bz;
    end
    task automatic pins(input logic rs, input logic cs);
        @(negedge clock);
        read_sel = rs;
        cs_n = cs;
    endtask
    task automatic start(input logic hold);
        repeat (96) @(negedge clock);
        pins(1'b0, 1'b1);
        repeat (2) @(negedge clock);
        pins(1'b0, 1'b0);
        if (!hold)
            pins(1'b0, 1'b1);
    endtask
    task automatic read(output logic [15:0] d);
        pins(1'b1, 1'b0);
        @(negedge clock);
        d = bus;
        pins(1'b1, 1'b1);
    endtask
endmodule

// ===== dv/sapr_top_tb.sv
// Purpose: Self-checking bench of the converter readout block
// Assumes: Short conversion count, host model drives the pins
// Notes: Raw codes are offset binary, results two's complement
// ************
// Bench
// ************
module sapr_top_tb
    import sapr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CONV = 4;
    // Raw code in the upper half, expected result in the lower
    logic [31:0] rows [5] = '{32'hffff7fff, 32'h80000000, 32'h7fffffff, 32'h00008000,
        32'h00018001};
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic sample_valid = 1'b0;
    logic [15:0] sample_data = 16'h0000;
    logic read_sel;
    logic cs_n;
    logic busy_n;
    logic sample_ready;
    logic result_fresh;
    logic [15:0] result_o;
    logic [15:0] result_oe;
    logic [15:0] got;
    int num_errors = 0;
    int samples_checked = 0;
    int lo;
    always #20 clock = ~clock;
    sapr_top #(.CONV_CNT(CONV)) uut (.clock(clock), .rstn(rstn), .read_sel(read_sel),
        .cs_n(cs_n), .busy_n(busy_n), .result_o(result_o), .result_oe(result_oe),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .sample_ready(sample_ready), .result_fresh(result_fresh));
    sapr_host_model host (.clock(clock), .result_o(result_o), .result_oe(result_oe),
        .read_sel(read_sel), .cs_n(cs_n));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Counts falling edges until busy shows the level; a hang ends the run
    task automatic wait_busy(input logic lvl);
        for (lo = 0; lo < 300 && busy_n !== lvl; lo++)
            @(negedge clock);
        if (lo == 300)
        begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic push(input logic [15:0] code);
        @(negedge clock);
        sample_valid = 1'b1;
        sample_data = code;
        @(negedge clock);
        sample_valid = 1'b0;
        sample_data = ~code;
    endtask
    task automatic conv(input logic [15:0] e);
        host.start(1'b0);
        wait_busy(1'b0);
        wait_busy(1'b1);
        chk(16'(lo), 16'(CONV));
        chk({15'h0000, result_fresh}, 16'h0001);
        host.read(got);
        chk(got, e);
    endtask
    initial
    begin
        repeat (6) @(negedge clock);
        chk({15'h0000, busy_n}, 16'h0001);
        chk(result_oe, 16'h0000);
        rstn = 1'b1;
        host.read(got);
        chk(got, RESULT_RESET);
        $display("reset test done");
        for (int i = 0; i < 5; i++)
        begin
            push(rows[i][31:16]);
            conv(rows[i][15:0]);
            host.read(got);
            chk(got, rows[i][15:0]);
        end
        $display("table test done");
        push(16'h1234);
        push(16'h4321);
        host.start(1'b0);
        host.pins(1'b0, 1'b0);
        host.pins(1'b0, 1'b1);
        wait_busy(1'b1);
        repeat (8) @(negedge clock);
        chk({15'h0000, busy_n}, 16'h0001);
        host.read(got);
        chk(got, 16'h9234);
        host.start(1'b0);
        host.pins(1'b1, 1'b0);
        @(negedge clock);
        chk(result_oe, 16'h0000);
        wait_busy(1'b1);
        chk(host.bus, 16'hc321);
        host.pins(1'b1, 1'b1);
        $display("ignored start and busy read tests done");
        push(16'h0f0f);
        push(16'hf0f0);
        host.start(1'b1);
        wait_busy(1'b0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk(16'(lo), 16'(REARM_CYCLES));
        host.pins(1'b1, 1'b1);
        wait_busy(1'b1);
        host.read(got);
        chk(got, 16'h70f0);
        $display("restart test done");
        for (int i = 0; i < 8; i++)
            push(16'(i));
        chk({15'h0000, sample_ready}, 16'h0000);
        for (int i = 0; i < 8; i++)
            conv(16'(i) ^ 16'h8000);
        host.start(1'b0);
        repeat (CONV + 6) @(negedge clock);
        chk({15'h0000, busy_n}, 16'h0000);
        push(16'h8001);
        wait_busy(1'b1);
        host.read(got);
        chk(got, 16'h0001);
        $display("buffer test done");
        summarize();
    end
endmodule
